// *** design/asram_pkg.sv ***
// Constants for the host controller of an asynchronous 128K x 16 static memory.
`default_nettype none
package asram_pkg;
  localparam int          CLK_PERIOD_NS     = 100;
  localparam int          ADDR_W            = 17;
  localparam int          DATA_W            = 16;
  localparam int          READ_CYCLE_NS     = 45;
  localparam int          READ_ACCESS_NS    = 45;
  localparam int          WRITE_PULSE_NS    = 35;
  localparam int          WRITE_CYCLE_NS    = 45;
  localparam int          WRITE_DATA_SETUP_NS = 25;
  localparam int          WRITE_LOW_TO_FLOAT_NS = 18;
  localparam int          FLOAT_NS          = 18;
  localparam int          RECOVERY_NS       = 45;
  localparam int          CNT_W             = 4;
  // Cycles are rounded up so every minimum is met even at the slowest corner.
  localparam logic [CNT_W-1:0] READ_CYC  =
    CNT_W'((READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int          WR_MIN_NS =
    (WRITE_PULSE_NS > WRITE_LOW_TO_FLOAT_NS + WRITE_DATA_SETUP_NS) ?
    WRITE_PULSE_NS : WRITE_LOW_TO_FLOAT_NS + WRITE_DATA_SETUP_NS;
  localparam logic [CNT_W-1:0] WRITE_CYC =
    CNT_W'((WR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] FLOAT_CYC =
    CNT_W'((FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RECOVERY_CYC =
    CNT_W'((RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  typedef enum logic [2:0] {
    ASRAM_RECOVER = 3'h0,
    ASRAM_IDLE    = 3'h1,
    ASRAM_READ    = 3'h2,
    ASRAM_WRITE   = 3'h3,
    ASRAM_TURN    = 3'h4
  } asram_state_t;
endpackage : asram_pkg
`default_nettype wire

// *** design/asram_host.sv ***
// Clocked host that sequences the strobes of an asynchronous static memory.
`default_nettype none
module asram_host (
  input  wire logic                          clk_i,
  input  wire logic                          reset_i,
  input  wire logic                          req_valid_i,
  output logic                               req_ready_o,
  input  wire logic                          req_write_i,
  input  wire logic [asram_pkg::ADDR_W-1:0]  req_addr_i,
  input  wire logic [asram_pkg::DATA_W-1:0]  req_wdata_i,
  input  wire logic [1:0]                    req_lanes_i,
  input  wire logic                          retain_i,
  output logic                               rsp_valid_o,
  output logic [asram_pkg::DATA_W-1:0]       rsp_rdata_o,
  output logic [asram_pkg::ADDR_W-1:0]       mem_addr_o,
  output logic                               chip_select_n_o,
  output logic                               write_strobe_n_o,
  output logic                               output_drive_n_o,
  output logic                               upper_lane_select_n_o,
  output logic                               lower_lane_select_n_o,
  input  wire logic [asram_pkg::DATA_W-1:0]  mem_data_i,
  output logic [asram_pkg::DATA_W-1:0]       mem_data_o,
  output logic                               mem_data_oe_o
);
  // Each register has a next_ twin; the state machine process computes all but the synchroniser twins.
  asram_pkg::asram_state_t                state;
  asram_pkg::asram_state_t                next_state;
  logic [asram_pkg::CNT_W-1:0]            cnt;
  logic [asram_pkg::CNT_W-1:0]            next_cnt;
  logic [asram_pkg::ADDR_W-1:0]           next_addr;
  logic [asram_pkg::DATA_W-1:0]           wdata;
  logic [asram_pkg::DATA_W-1:0]           next_wdata;
  logic [1:0]                             lanes_n;
  logic [1:0]                             next_lanes_n;
  // Registered strobes, so the memory only ever sees clean edges.
  logic                                   cs_n;
  logic                                   next_cs_n;
  logic                                   we_n;
  logic                                   next_we_n;
  logic                                   oe_n;
  logic                                   next_oe_n;
  logic                                   doe;
  logic                                   next_doe;
  // Response registers; the read data holds until the next read answer.
  logic                                   rvalid;
  logic                                   next_rvalid;
  logic [asram_pkg::DATA_W-1:0]           rdata;
  logic [asram_pkg::DATA_W-1:0]           next_rdata;
  // Three-stage synchroniser for the data pins.
  logic [asram_pkg::DATA_W-1:0]           sync1;
  logic [asram_pkg::DATA_W-1:0]           sync2;
  logic [asram_pkg::DATA_W-1:0]           sync3;
  logic [asram_pkg::DATA_W-1:0]           next_sync1;
  logic [asram_pkg::DATA_W-1:0]           next_sync2;
  logic [asram_pkg::DATA_W-1:0]           next_sync3;
  logic                                   sync_same;

  // Read data is asynchronous to our clock, so it passes three flops per bit.
  // Only the second stage reads the first, so a metastable first stage stays contained.
  always_comb begin
    next_sync1 = mem_data_i;
    next_sync2 = sync1;
    next_sync3 = sync2;
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sync1 <= 16'h0000;
      sync2 <= 16'h0000;
      sync3 <= 16'h0000;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      sync3 <= next_sync3;
    end
  end

  // A word counts as settled once the last two stages agree.
  // Data that never settles stalls the read, which a static memory cannot cause.
  assign sync_same = (sync2 == sync3);

  // A request is taken only in idle, and never while retention is requested.
  assign req_ready_o = (state == asram_pkg::ASRAM_IDLE) && !retain_i;

  // One state machine sequences every strobe of the memory.
  always_comb begin
    next_state   = state;
    next_cnt     = cnt;
    next_addr    = mem_addr_o;
    next_wdata   = wdata;
    next_lanes_n = lanes_n;
    next_cs_n    = cs_n;
    next_we_n    = we_n;
    next_oe_n    = oe_n;
    next_doe     = doe;
    next_rvalid  = 1'b0;
    next_rdata   = rdata;
    case (state)
      asram_pkg::ASRAM_RECOVER: begin
        // Accesses wait out the recovery time after reset or retention.
        next_cs_n = 1'b1;
        if (retain_i) begin
          next_cnt = asram_pkg::RECOVERY_CYC;
        end else if (cnt <= asram_pkg::CNT_ONE) begin
          next_state = asram_pkg::ASRAM_IDLE;
        end else begin
          next_cnt = cnt - asram_pkg::CNT_ONE;
        end
      end
      asram_pkg::ASRAM_IDLE: begin
        // Retention takes chip select high first, then waits out the recovery time.
        if (retain_i) begin
          next_state = asram_pkg::ASRAM_RECOVER;
          next_cnt   = asram_pkg::RECOVERY_CYC;
        // A request that selects no lane would move no data, so it is left waiting.
        end else if (req_valid_i && req_lanes_i != 2'h0) begin
          // Address and lanes go out together with the strobes.
          next_addr    = req_addr_i;
          next_lanes_n = ~req_lanes_i;
          next_cs_n    = 1'b0;
          if (req_write_i) begin
            // Output drive stays high and data is driven from write start.
            next_we_n  = 1'b0;
            next_oe_n  = 1'b1;
            next_doe   = 1'b1;
            next_wdata = req_wdata_i;
            // The count covers the strobe pulse, the float delay and data set-up.
            next_cnt   = asram_pkg::WRITE_CYC;
            next_state = asram_pkg::ASRAM_WRITE;
          end else begin
            next_oe_n  = 1'b0;
            // Extra cycles cover the three-flop capture of read data.
            next_cnt   = asram_pkg::READ_CYC + 4'h3;
            next_state = asram_pkg::ASRAM_READ;
          end
        end
      end
      asram_pkg::ASRAM_READ: begin
        if (cnt > asram_pkg::CNT_ONE) begin
          next_cnt = cnt - asram_pkg::CNT_ONE;
        end else if (sync_same) begin
          // Capture waits for agreement, so a byte still in flight is never returned.
          // Bytes of lanes that were not selected read as zero.
          next_rdata   = sync3 & {{8{~lanes_n[1]}}, {8{~lanes_n[0]}}};
          next_rvalid  = 1'b1;
          next_cs_n    = 1'b1;
          next_oe_n    = 1'b1;
          next_lanes_n = 2'h3;
          next_cnt     = asram_pkg::FLOAT_CYC;
          next_state   = asram_pkg::ASRAM_TURN;
        end
      end
      asram_pkg::ASRAM_WRITE: begin
        if (cnt <= asram_pkg::CNT_ONE) begin
          // All strobes rise together; data and address hold through this edge.
          next_we_n    = 1'b1;
          next_cs_n    = 1'b1;
          next_lanes_n = 2'h3;
          next_cnt     = asram_pkg::CNT_ONE;
          next_state   = asram_pkg::ASRAM_TURN;
        end else begin
          next_cnt = cnt - asram_pkg::CNT_ONE;
        end
      end
      asram_pkg::ASRAM_TURN: begin
        // Gap between accesses keeps each cycle at least its minimum length.
        // Data drive drops one cycle after the strobes, so every lane keeps its hold.
        next_doe = 1'b0;
        if (cnt <= asram_pkg::CNT_ONE) begin
          next_state = asram_pkg::ASRAM_IDLE;
        end else begin
          next_cnt = cnt - asram_pkg::CNT_ONE;
        end
      end
      default: begin
        // An illegal state falls back to a full recovery rather than guessing.
        next_state = asram_pkg::ASRAM_RECOVER;
        next_cnt   = asram_pkg::RECOVERY_CYC;
      end
    endcase
  end

  // Every pin leaves a flop, so the memory sees edges one clock apart.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state      <= asram_pkg::ASRAM_RECOVER;
      cnt        <= asram_pkg::RECOVERY_CYC;
      mem_addr_o <= 17'h00000;
      wdata      <= 16'h0000;
      lanes_n    <= 2'h3;
      cs_n       <= 1'b1;
      we_n       <= 1'b1;
      oe_n       <= 1'b1;
      doe        <= 1'b0;
      rvalid     <= 1'b0;
      rdata      <= 16'h0000;
    end else begin
      state      <= next_state;
      cnt        <= next_cnt;
      mem_addr_o <= next_addr;
      wdata      <= next_wdata;
      lanes_n    <= next_lanes_n;
      cs_n       <= next_cs_n;
      we_n       <= next_we_n;
      oe_n       <= next_oe_n;
      doe        <= next_doe;
      rvalid     <= next_rvalid;
      rdata      <= next_rdata;
    end
  end

  // Pins mirror the registers directly; no logic sits between flop and pad.
  assign chip_select_n_o       = cs_n;
  assign write_strobe_n_o      = we_n;
  assign output_drive_n_o      = oe_n;
  assign upper_lane_select_n_o = lanes_n[1];
  assign lower_lane_select_n_o = lanes_n[0];
  assign mem_data_o            = wdata;
  assign mem_data_oe_o         = doe;
  assign rsp_valid_o           = rvalid;
  assign rsp_rdata_o           = rdata;
endmodule : asram_host
`default_nettype wire

// *** verif/asram_host_asserts.sv ***
// Pin timing checks for the static memory host.
`default_nettype none
module asram_host_asserts (
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic        req_valid_i,
  input wire logic        req_ready_o,
  input wire logic        req_write_i,
  input wire logic [1:0]  req_lanes_i,
  input wire logic [15:0] req_wdata_i,
  input wire logic        retain_i,
  input wire logic        rsp_valid_o,
  input wire logic [16:0] mem_addr_o,
  input wire logic        chip_select_n_o,
  input wire logic        write_strobe_n_o,
  input wire logic        output_drive_n_o,
  input wire logic        upper_lane_select_n_o,
  input wire logic        lower_lane_select_n_o,
  input wire logic [15:0] mem_data_o,
  input wire logic        mem_data_oe_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  wire       take    = req_valid_i && req_ready_o && req_lanes_i != 2'h0;
  wire [1:0] lanes_n = {upper_lane_select_n_o, lower_lane_select_n_o};
  read_start_a: assert property (
    take && !req_write_i |=> !chip_select_n_o && !output_drive_n_o && write_strobe_n_o
    && lanes_n == ~$past(req_lanes_i)) else $error("read strobes wrong");
  read_hold_a: assert property (
    take && !req_write_i |=> !chip_select_n_o [*4] ##1 chip_select_n_o)
    else $error("read strobe length wrong");
  read_answer_a: assert property (
    take && !req_write_i |-> ##5 rsp_valid_o) else $error("read answer late");
  rsp_float_a: assert property (
    rsp_valid_o |-> chip_select_n_o && output_drive_n_o && !req_ready_o ##1 !rsp_valid_o)
    else $error("answer pulse or float gap wrong");
  write_start_a: assert property (
    take && req_write_i |=> !chip_select_n_o && !write_strobe_n_o && output_drive_n_o
    && mem_data_oe_o && lanes_n == ~$past(req_lanes_i) && mem_data_o == $past(req_wdata_i))
    else $error("write strobes wrong");
  write_end_a: assert property (
    take && req_write_i |-> ##2 chip_select_n_o && write_strobe_n_o && lanes_n == 2'h3
    && mem_data_oe_o && $stable(mem_data_o) && $stable(mem_addr_o))
    else $error("write end wrong");
  no_fight_a: assert property (
    !output_drive_n_o |-> !mem_data_oe_o) else $error("data pins driven twice");
  retain_off_a: assert property (
    retain_i |-> !req_ready_o) else $error("ready during retention");
  recover_wait_a: assert property (
    $fell(retain_i) |-> !req_ready_o) else $error("no recovery wait");
  cover property (take && !req_write_i);
  cover property (take && req_write_i);
  cover property ($fell(retain_i));
endmodule : asram_host_asserts
`default_nettype wire

// *** verif/asram_mem_model.sv ***
// Behavioural static memory answering the host strobes.
`default_nettype none
module asram_mem_model (
  input wire logic [16:0] addr_i,
  input wire logic        cs_n_i,
  input wire logic        we_n_i,
  input wire logic        oe_n_i,
  input wire logic        ub_n_i,
  input wire logic        lb_n_i,
  input wire logic [15:0] data_i,
  input wire logic        data_oe_i,
  output logic [15:0]     data_o,
  output logic            fault_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] mem [0:131071];
  logic        act;
  logic [1:0]  lane;
  realtime     t_wr;
  realtime     t_dat;
  wire [15:0]  word = mem[addr_i];
  wire         rd   = !cs_n_i && we_n_i && !oe_n_i;
  // Released lanes show the inverse byte so a stale value can never pass for read data.
  assign #20 data_o = rd ? {ub_n_i ? ~word[15:8] : word[15:8],
                            lb_n_i ? ~word[7:0] : word[7:0]} : ~word;
  initial fault_o = 1'b0;
  always @(data_i) t_dat = $realtime;
  always @(rd or data_oe_i) if (rd && data_oe_i) fault_o = 1'b1;
  always @(cs_n_i or we_n_i or ub_n_i or lb_n_i) begin
    if (act) begin
      if ($realtime - t_wr < 35.0 || $realtime - t_dat < 25.0) fault_o = 1'b1;
      if (lane[1]) mem[addr_i][15:8] = data_i[15:8];
      if (lane[0]) mem[addr_i][7:0] = data_i[7:0];
    end
    act = !cs_n_i && !we_n_i && !(ub_n_i && lb_n_i);
    lane = {!ub_n_i, !lb_n_i};
    if (act) t_wr = $realtime;
  end
endmodule : asram_mem_model
`default_nettype wire

// *** verif/async_sram_access_timing_tb_top.sv ***
// Self-checking bench for the static memory host.
`default_nettype none
module async_sram_access_timing_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'h0, reset_i = 1'h1, req_valid_i = 1'h0, req_write_i = 1'h0, retain_i = 1'h0;
  logic [16:0] req_addr_i = 17'h0, mem_addr_o;
  logic [15:0] req_wdata_i = 16'h0, rsp_rdata_o, mem_data_o, mem_q;
  logic [1:0]  req_lanes_i = 2'h0;
  logic req_ready_o, rsp_valid_o, chip_select_n_o, write_strobe_n_o, output_drive_n_o;
  logic upper_lane_select_n_o, lower_lane_select_n_o, mem_data_oe_o, fault;
  wire [15:0]  pins = mem_data_oe_o ? mem_data_o : mem_q;
  int          n_errors = 0;
  int          check_count = 0;
  asram_host dut (.clk_i, .reset_i, .req_valid_i, .req_ready_o, .req_write_i, .req_addr_i,
    .req_wdata_i, .req_lanes_i, .retain_i, .rsp_valid_o, .rsp_rdata_o, .mem_addr_o,
    .chip_select_n_o, .write_strobe_n_o, .output_drive_n_o, .upper_lane_select_n_o,
    .lower_lane_select_n_o, .mem_data_i(pins), .mem_data_o, .mem_data_oe_o);
  asram_mem_model mem (.addr_i(mem_addr_o), .cs_n_i(chip_select_n_o), .we_n_i(write_strobe_n_o),
    .oe_n_i(output_drive_n_o), .ub_n_i(upper_lane_select_n_o), .lb_n_i(lower_lane_select_n_o),
    .data_i(mem_data_o), .data_oe_i(mem_data_oe_o), .data_o(mem_q), .fault_o(fault));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic stop_test;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  // One request; a read returns its data and the negedges from take to answer.
  task automatic access(input logic wr, input logic [16:0] a, input logic [15:0] d,
                        input logic [1:0] ln, output logic [15:0] q, output int lat);
    int n;
    n = 0;
    lat = 0;
    @(negedge clk_i);
    {req_valid_i, req_write_i, req_addr_i, req_wdata_i, req_lanes_i} = {1'h1, wr, a, d, ln};
    while (req_ready_o !== 1'h1 && n < 50) begin
      @(negedge clk_i);
      n++;
    end
    @(negedge clk_i);
    req_valid_i = 1'h0;
    while (!wr && rsp_valid_o !== 1'h1 && lat < 20) begin
      @(negedge clk_i);
      lat++;
    end
    q = rsp_rdata_o;
  endtask : access
  task automatic sc_lanes;
    logic [15:0] q;
    int          lat;
    access(1'h1, 17'h1FFFF, 16'h1234, 2'h3, q, lat);
    access(1'h1, 17'h1FFFF, 16'hABCD, 2'h2, q, lat);
    access(1'h1, 17'h00000, 16'hC33C, 2'h3, q, lat);
    access(1'h1, 17'h00000, 16'h0F5A, 2'h1, q, lat);
    access(1'h0, 17'h1FFFF, 16'h0, 2'h3, q, lat);
    check(q, 16'hAB34);
    check(lat, 4);
    access(1'h0, 17'h1FFFF, 16'h0, 2'h2, q, lat);
    check(q, 16'hAB00);
    access(1'h0, 17'h00000, 16'h0, 2'h1, q, lat);
    check(q, 16'h005A);
  endtask : sc_lanes
  task automatic sc_no_lanes;
    @(negedge clk_i);
    {req_valid_i, req_write_i, req_lanes_i} = {1'h1, 1'h1, 2'h0};
    repeat (3) @(negedge clk_i);
    check({req_ready_o, chip_select_n_o}, 2'h3);
    req_valid_i = 1'h0;
  endtask : sc_no_lanes
  task automatic sc_retain;
    logic [15:0] q;
    int          lat;
    @(negedge clk_i);
    retain_i = 1'h1;
    repeat (3) @(negedge clk_i);
    check({req_ready_o, chip_select_n_o}, 2'h1);
    retain_i = 1'h0;
    check(req_ready_o, 1'h0);
    @(negedge clk_i);
    check(req_ready_o, 1'h1);
    access(1'h0, 17'h00000, 16'h0, 2'h3, q, lat);
    check(q, 16'hC35A);
  endtask : sc_retain
  initial forever #50 clk_i = ~clk_i;
  initial begin
    #100000;
    n_errors++;
    stop_test();
  end
  initial begin
    repeat (4) @(negedge clk_i);
    reset_i = 1'h0;
    sc_lanes();
    sc_no_lanes();
    sc_retain();
    check(fault, 1'h0);
    stop_test();
  end
endmodule : async_sram_access_timing_tb_top
bind asram_host asram_host_asserts chk (.clk_i, .reset_i, .req_valid_i, .req_ready_o,
  .req_write_i, .req_lanes_i, .req_wdata_i, .retain_i, .rsp_valid_o, .mem_addr_o,
  .chip_select_n_o, .write_strobe_n_o, .output_drive_n_o, .upper_lane_select_n_o,
  .lower_lane_select_n_o, .mem_data_o, .mem_data_oe_o);
`default_nettype wire
